// ---- core/flp_pkg.sv ----
// Package with opcodes, field positions, reset values and timing counts.
package flp_pkg;

  // Command opcodes decoded from the first byte of a frame.
  localparam logic [7:0] OP_STATUS_READ    = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_STATUS_CLEAR   = 8'h30;
  localparam logic [7:0] OP_LOCK_CLEAR     = 8'ha6;
  localparam logic [7:0] OP_LOCK_READ      = 8'ha7;
  localparam logic [7:0] OP_PWD_READ       = 8'he7;
  localparam logic [7:0] OP_PWD_PROGRAM    = 8'he8;
  localparam logic [7:0] OP_PWD_UNLOCK     = 8'he9;
  localparam logic [7:0] OP_SOFT_RESET     = 8'hf0;
  localparam logic [7:0] OP_MODE_BIT_RESET = 8'hff;

  // Frame lengths, bit count limit and read latency in serial clocks.
  localparam logic [6:0] CMD_LEN = 7'h08;
  localparam logic [6:0] PWD_LEN = 7'h48;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [5:0] RD_LAT  = 6'h08;

  // Status byte field positions and lock bit position.
  localparam int STS_BUSY_POS = 0;
  localparam int STS_WEL_POS  = 1;
  localparam int STS_ERR_POS  = 6;
  localparam int LOCK_POS     = 0;

  // Reset values.
  localparam logic [7:0]  LOCK_PWD_MODE   = 8'h00;
  localparam logic [7:0]  LOCK_PERSIST    = 8'h01;
  localparam logic [63:0] PWD_ERASED      = 64'hffff_ffff_ffff_ffff;

  // Timing: clock period, self-timed operation time, reset hold time.
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int OP_TIME_NS      = 1000;
  localparam int RST_HOLD_NS     = 100;
  localparam int OP_CYCLES       =
    (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_HOLD_CYCLES =
    (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Operation sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_FAIL = 2'b10
  } flp_state_t;

  // Kind of self-timed operation in progress.
  typedef enum logic [1:0] {
    OPK_NONE   = 2'b00,
    OPK_LCLR   = 2'b01,
    OPK_PPROG  = 2'b10,
    OPK_UNLOCK = 2'b11
  } flp_op_t;

  // Read-out source selected for the data phase of a frame.
  typedef enum logic [1:0] {
    RD_NONE = 2'b00,
    RD_STS  = 2'b01,
    RD_LOCK = 2'b10,
    RD_PWD  = 2'b11
  } flp_rd_t;

endpackage

// ---- core/flp_lock_cmd.sv ----
// Lock register, password and reset command interpreter of a serial flash.
//
// Operation
// - Opcode a7 shifts the 8-bit lock register out after the opcode.
// - Lock register read repeats the same byte every further eight clocks.
// - Opcode a6 with write enable latched clears the lock register, self-timed.
// - Lock clear needs a prior decoded write enable setting the latch.
// - Lock clear runs only if select rises right after eight bits.
// - Lock clear holds busy at one, then clears busy and write enable.
// - Opcode e7 shifts password out, low byte first, msb first, falling edge.
// - Password read repeats the whole password every further 64 clocks.
// - Password read is ignored once password protection mode is selected.
// - Password program e8 is accepted only with write enable latched.
// - Password program is ignored once password mode bit is zero.
// - Program runs only after exactly 64 data bits; busy; error; clears latch.
// - Unlock e9 checks 64 bits only if select rises right after them.
// - Unlock mismatch sets error, keeps busy until clear or reset.
// - Unlock match sets the lock bit to one.
// - Soft reset f0 restores power-up state but keeps freeze, lock and password.
// - Soft reset reloads protect bits only when volatile and not frozen.
// - Only hardware reset clears freeze and reloads the lock bit.
// - Soft reset runs at select rise; a hold time follows.
// - Eight ones on the data input leave continuous read mode.
// - Status clear 30 clears the failure and its stuck busy state.
`timescale 1ns/1ps
`default_nettype none

module flp_lock_cmd
  import flp_pkg::*;
#(
  parameter int OP_CYC   = OP_CYCLES,
  parameter int HOLD_CYC = RST_HOLD_CYCLES
) (
  // System clock, reset and enable.
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  // Serial link from the host.
  input  wire logic       sck_in,
  input  wire logic       cs_b_in,
  input  wire logic       si_in,
  output logic            so_out,
  output logic            so_oe_out,
  // Configuration and events from neighbouring logic.
  input  wire logic       pwd_mode_bit_in,
  input  wire logic       bp_volatile_in,
  input  wire logic [2:0] bp_nv_value_in,
  input  wire logic       bp_wr_in,
  input  wire logic [2:0] bp_wr_data_in,
  input  wire logic       freeze_set_in,
  input  wire logic       cont_read_enter_in,
  input  wire logic       prog_fail_in,
  // Status.
  output logic            busy_flag_out,
  output logic            wr_en_latch_out,
  output logic            prog_err_out,
  output logic [7:0]      lock_reg_out,
  output logic            freeze_out,
  output logic [2:0]      block_protect_out,
  output logic            cont_read_out,
  output logic            reset_hold_out
);

  // Refuse counts that do not fit the 16-bit timers.
  if (OP_CYC < 1 || OP_CYC > 65535 || HOLD_CYC < 1 || HOLD_CYC > 65535)
  begin : g_chk
    $error("flp_lock_cmd: cycle counts must lie in 1..65535");
  end

  // Reverses byte order: first received byte lands in the low byte.
  function automatic logic [63:0] byte_swap(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[b*8 +: 8] = v[(7-b)*8 +: 8];
    end
    return r;
  endfunction

  // True when a finished frame carried the given opcode and length.
  function automatic logic frame_is(input logic [7:0] op,
                                    input logic [6:0] cnt,
                                    input logic [7:0] want_op,
                                    input logic [6:0] want_cnt);
    return (op == want_op) && (cnt == want_cnt);
  endfunction

  // ------------------------------------------------------------------
  // Link domain, clocked by the serial clock.
  // ------------------------------------------------------------------
  logic        frame_rst_b;
  logic        started_r;
  logic [6:0]  bit_cnt_r;
  logic [5:0]  phase_r;
  logic [63:0] shift_r;
  logic [7:0]  op_r;
  flp_rd_t     rd_sel_r;
  logic [5:0]  lk_s1_r;
  logic [5:0]  lk_s2_r;
  logic        so_r;
  logic        so_oe_r;
  logic [5:0]  rd_idx;

  // Frame-local state is cleared while select is high.
  assign frame_rst_b = rst_b_in & ~cs_b_in;

  // Marks that the frame has seen its first rising edge.
  always_ff @(posedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      started_r <= 1'b0;
      phase_r   <= 6'h00;
    end else begin
      started_r <= 1'b1;
      phase_r   <= started_r ? phase_r + 6'h01 : 6'h01;
    end
  end

  // Frame contents survive select rising so the system side can read them.
  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_r <= 7'h00;
      shift_r   <= 64'h0;
      op_r      <= 8'h00;
    end else begin
      shift_r <= {shift_r[62:0], si_in};
      if (!started_r) begin
        bit_cnt_r <= 7'h01;
      end else if (bit_cnt_r != CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 7'h01;
      end
      if (started_r && bit_cnt_r == CMD_LEN - 7'h01) begin
        op_r <= {shift_r[6:0], si_in};
      end
    end
  end

  // Two-flop synchronisers for system flags seen by the read-out.
  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lk_s1_r <= 6'h00;
      lk_s2_r <= 6'h00;
    end else begin
      lk_s1_r <= {pwd_mode_bit_in, cont_read_r, busy_w,
                  prog_err_r, wel_r, busy_flag_r};
      lk_s2_r <= lk_s1_r;
    end
  end

  // Read source is chosen on the eighth rising edge.
  always_ff @(posedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      rd_sel_r <= RD_NONE;
    end else if (started_r && bit_cnt_r == CMD_LEN - 7'h01 && !lk_s2_r[4])
    begin
      case ({shift_r[6:0], si_in})
        OP_STATUS_READ: rd_sel_r <= RD_STS;
        OP_LOCK_READ:   rd_sel_r <= lk_s2_r[3] ? RD_NONE : RD_LOCK;
        OP_PWD_READ:    rd_sel_r <= (lk_s2_r[3] || !lk_s2_r[5]) ?
                                    RD_NONE : RD_PWD;
        default:        rd_sel_r <= RD_NONE;
      endcase
    end
  end

  // Bit index since the data phase began; wraps for repeated reads.
  assign rd_idx = phase_r - RD_LAT;

  // Output shifts on falling edges; lock and password stay still while
  // idle, and reads of them are refused while busy, so they are stable.
  always_ff @(negedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= (rd_sel_r != RD_NONE);
      case (rd_sel_r)
        RD_STS:  so_r <= sts_byte_w[~rd_idx[2:0]];
        RD_LOCK: so_r <= lock_r[~rd_idx[2:0]];
        RD_PWD:  so_r <= pwd_r[{rd_idx[5:3], ~rd_idx[2:0]}];
        default: so_r <= 1'b0;
      endcase
    end
  end

  assign so_out    = so_r;
  assign so_oe_out = so_oe_r;

  // ------------------------------------------------------------------
  // System domain.
  // ------------------------------------------------------------------
  logic        cs_s1_r;
  logic        cs_s2_r;
  logic        cs_s3_r;
  logic        frame_end_w;
  logic        busy_w;
  logic        go_write_enable_cmd;
  logic        go_status_clear_cmd;
  logic        go_srst;
  logic        go_lclr;
  logic        go_pprog;
  logic        go_unlk;
  logic        go_mbr;
  logic        done_w;
  logic        fail_w;
  flp_state_t  state_r;
  flp_state_t  state_nxt;
  flp_op_t     op_kind_r;
  logic [15:0] op_cnt_r;
  logic [15:0] hold_cnt_r;
  logic [63:0] cand_r;
  logic [63:0] pwd_r;
  logic [7:0]  lock_r;
  logic        busy_flag_r;
  logic        prog_err_r;
  logic        wel_r;
  logic        freeze_r;
  logic [2:0]  bp_r;
  logic        cont_read_r;
  logic        por_load_r;
  logic [7:0]  sts_byte_w;

  // Select is synchronised; its rising edge marks a finished frame.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
    end else if (clk_en_in) begin
      cs_s1_r <= cs_b_in;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end

  assign frame_end_w = clk_en_in && cs_s2_r && !cs_s3_r;
  assign busy_w      = (state_r != ST_IDLE) || (hold_cnt_r != 16'h0);

  // Status byte as returned by a status read.
  always_comb begin
    sts_byte_w               = 8'h00;
    sts_byte_w[STS_BUSY_POS] = lk_s2_r[0];
    sts_byte_w[STS_WEL_POS]  = lk_s2_r[1];
    sts_byte_w[STS_ERR_POS]  = lk_s2_r[2];
  end

  // Command acceptance at the end of a frame.
  always_comb begin
    go_mbr   = frame_end_w && cont_read_r && bit_cnt_r >= CMD_LEN &&
               op_r == OP_MODE_BIT_RESET;
    go_write_enable_cmd  = frame_end_w && !cont_read_r && !busy_w &&
               frame_is(op_r, bit_cnt_r, OP_WRITE_ENABLE, CMD_LEN);
    go_status_clear_cmd  = frame_end_w && !cont_read_r && hold_cnt_r == 16'h0 &&
               frame_is(op_r, bit_cnt_r, OP_STATUS_CLEAR, CMD_LEN);
    go_srst  = frame_end_w && !cont_read_r &&
               frame_is(op_r, bit_cnt_r, OP_SOFT_RESET, CMD_LEN);
    go_lclr  = frame_end_w && !cont_read_r && !busy_w && wel_r &&
               frame_is(op_r, bit_cnt_r, OP_LOCK_CLEAR, CMD_LEN);
    go_pprog = frame_end_w && !cont_read_r && !busy_w && wel_r &&
               pwd_mode_bit_in &&
               frame_is(op_r, bit_cnt_r, OP_PWD_PROGRAM, PWD_LEN);
    go_unlk  = frame_end_w && !cont_read_r && !busy_w &&
               frame_is(op_r, bit_cnt_r, OP_PWD_UNLOCK, PWD_LEN);
  end

  assign done_w = (state_r == ST_BUSY) && (op_cnt_r == 16'h0);
  assign fail_w = ((op_kind_r == OPK_PPROG) && prog_fail_in) ||
                  ((op_kind_r == OPK_UNLOCK) && (cand_r != pwd_r));

  // Next state of the operation sequencer.
  always_comb begin
    state_nxt = state_r;
    if (go_srst || (go_status_clear_cmd && state_r == ST_FAIL)) begin
      state_nxt = ST_IDLE;
    end else if (go_lclr || go_pprog || go_unlk) begin
      state_nxt = ST_BUSY;
    end else if (done_w) begin
      state_nxt = fail_w ? ST_FAIL : ST_IDLE;
    end
  end

  // Sequencer, operation timer and the flags derived from its state.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r     <= ST_IDLE;
      op_kind_r   <= OPK_NONE;
      op_cnt_r    <= 16'h0;
      busy_flag_r <= 1'b0;
      prog_err_r  <= 1'b0;
      cand_r      <= 64'h0;
    end else if (clk_en_in) begin
      state_r     <= state_nxt;
      busy_flag_r <= (state_nxt != ST_IDLE);
      prog_err_r  <= (state_nxt == ST_FAIL);
      if (go_lclr || go_pprog || go_unlk) begin
        op_kind_r <= go_lclr ? OPK_LCLR : (go_pprog ? OPK_PPROG : OPK_UNLOCK);
        op_cnt_r  <= 16'(OP_CYC - 1);
        cand_r    <= byte_swap(shift_r);
      end else if (state_r == ST_BUSY && op_cnt_r != 16'h0) begin
        op_cnt_r <= op_cnt_r - 16'h1;
      end
    end
  end

  // Write enable latch: set by decode, cleared at lock clear or program completion or reset.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wel_r <= 1'b0;
    end else if (clk_en_in) begin
      if (go_write_enable_cmd) begin
        wel_r <= 1'b1;
      end else if (go_srst ||
                   (done_w && op_kind_r != OPK_UNLOCK)) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Lock register and stored password.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_r     <= LOCK_PWD_MODE;
      pwd_r      <= PWD_ERASED;
      por_load_r <= 1'b1;
    end else if (clk_en_in) begin
      por_load_r <= 1'b0;
      if (por_load_r) begin
        lock_r <= pwd_mode_bit_in ? LOCK_PERSIST : LOCK_PWD_MODE;
      end else if (done_w && op_kind_r == OPK_LCLR) begin
        lock_r <= 8'h00;
      end else if (done_w && op_kind_r == OPK_UNLOCK && !fail_w) begin
        lock_r[LOCK_POS] <= 1'b1;
      end
      if (done_w && op_kind_r == OPK_PPROG && !fail_w) begin
        pwd_r <= cand_r;
      end
    end
  end

  // Freeze and volatile block protect bits.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      freeze_r <= 1'b0;
      bp_r     <= 3'h0;
    end else if (clk_en_in) begin
      if (freeze_set_in) begin
        freeze_r <= 1'b1;
      end
      if (por_load_r) begin
        bp_r <= bp_nv_value_in;
      end else if (go_srst && bp_volatile_in && !freeze_r) begin
        bp_r <= bp_nv_value_in;
      end else if (bp_wr_in && !freeze_r) begin
        bp_r <= bp_wr_data_in;
      end
    end
  end

  // Reset hold timer and continuous read mode flag.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_cnt_r  <= 16'h0;
      cont_read_r <= 1'b0;
    end else if (clk_en_in) begin
      if (go_srst) begin
        hold_cnt_r <= 16'(HOLD_CYC);
      end else if (hold_cnt_r != 16'h0) begin
        hold_cnt_r <= hold_cnt_r - 16'h1;
      end
      if (cont_read_enter_in) begin
        cont_read_r <= 1'b1;
      end else if (go_mbr) begin
        cont_read_r <= 1'b0;
      end
    end
  end

  assign busy_flag_out     = busy_flag_r;
  assign wr_en_latch_out   = wel_r;
  assign prog_err_out      = prog_err_r;
  assign lock_reg_out      = lock_r;
  assign freeze_out        = freeze_r;
  assign block_protect_out = bp_r;
  assign cont_read_out     = cont_read_r;
  assign reset_hold_out    = (hold_cnt_r != 16'h0);

  // Checks on the system-side behaviour.
  property p_lclr_start;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      go_lclr |=> busy_flag_r && state_r == ST_BUSY && op_kind_r == OPK_LCLR;
  endproperty
  a_lclr_start: assert property (p_lclr_start)
    else $error("lock clear did not start");

  property p_no_wel_no_change;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      frame_end_w && !wel_r && !busy_w &&
      frame_is(op_r, bit_cnt_r, OP_LOCK_CLEAR, CMD_LEN)
      |=> !busy_flag_r && lock_r == $past(lock_r);
  endproperty
  a_no_wel_no_change: assert property (p_no_wel_no_change)
    else $error("lock clear acted without write enable");

  property p_busy_holds;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      $rose(busy_flag_r) && op_kind_r == OPK_LCLR
      |-> busy_flag_r [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy flag dropped during operation");

  property p_done_clears_wel;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      clk_en_in && done_w && op_kind_r != OPK_UNLOCK && !go_write_enable_cmd
      |=> !wel_r;
  endproperty
  a_done_clears_wel: assert property (p_done_clears_wel)
    else $error("write enable latch not cleared at completion");

  property p_unlock_fail;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      clk_en_in && done_w && op_kind_r == OPK_UNLOCK && cand_r != pwd_r
      |=> prog_err_r && busy_flag_r;
  endproperty
  a_unlock_fail: assert property (p_unlock_fail)
    else $error("unlock mismatch did not flag an error");

  property p_unlock_ok;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      clk_en_in && done_w && op_kind_r == OPK_UNLOCK && cand_r == pwd_r
      |=> lock_r[LOCK_POS] && !busy_flag_r;
  endproperty
  a_unlock_ok: assert property (p_unlock_ok)
    else $error("unlock match did not set the lock bit");

  property p_err_sticks;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      prog_err_r && !go_status_clear_cmd && !go_srst |=> prog_err_r;
  endproperty
  a_err_sticks: assert property (p_err_sticks)
    else $error("error flag cleared without a clear or reset");

  property p_srst_keeps;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      go_srst && !freeze_set_in
      |=> lock_r == $past(lock_r) && freeze_r == $past(freeze_r) &&
          !busy_flag_r && !wel_r;
  endproperty
  a_srst_keeps: assert property (p_srst_keeps)
    else $error("soft reset disturbed lock or freeze");

  property p_prog_mode_ignored;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      frame_end_w && !pwd_mode_bit_in && !busy_w &&
      frame_is(op_r, bit_cnt_r, OP_PWD_PROGRAM, PWD_LEN)
      |=> !busy_flag_r;
  endproperty
  a_prog_mode_ignored: assert property (p_prog_mode_ignored)
    else $error("password program ran in password mode");

  property p_mbr_exit;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      go_mbr && !cont_read_enter_in |=> !cont_read_r;
  endproperty
  a_mbr_exit: assert property (p_mbr_exit)
    else $error("mode bit reset did not leave continuous read");

endmodule

`default_nettype wire

// ---- verif/flp_host_model.sv ----
// Host serial controller model that frames commands toward the device.
`timescale 1ns/1ps
`default_nettype none

module flp_host_model (
  // Link lines toward the device.
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      si_out,
  // Device answer.
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  // The serial clock rests low and select rests high between frames.
  initial begin
    sck_out  = 1'b0;
    cs_b_out = 1'b1;
    si_out   = 1'b0;
  end

  // Shifts n bits of tx msb first at a 64 ns period and gathers the answer.
  task automatic frame(input int n, input logic [143:0] tx,
                       output logic [143:0] rx, output logic oe);
    rx = '0;
    oe = 1'b0;
    #1.3;
    cs_b_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = tx[i];
      #32;
      sck_out = 1'b1;
      rx      = {rx[142:0], so_in};
      oe      = so_oe_in;
      #32;
      sck_out = 1'b0;
    end
    #8;
    cs_b_out = 1'b1;  // Right after the last bit.
    si_out   = ~si_out;  // Released line no longer shows the last bit.
  endtask
endmodule

`default_nettype wire

// ---- verif/test_flp_lock_cmd.sv ----
// Self-checking bench for the lock, password and reset command logic.
`timescale 1ns/1ps
`default_nettype none

module test_flp_lock_cmd;
  logic         sys_clk_in, rst_b_in, pwd_mode, bp_vol, bp_wr, frz_set, cr_in;
  logic         clk_en, prog_fail;
  wire logic    sck, cs_b, si, so, so_oe, busy, write_enable_latch, perr, frz, cr, hold;
  wire logic [7:0] lock;
  wire logic [2:0] bp;
  logic [143:0] rx;
  logic         oe;
  logic [63:0]  ps;
  int           bad_count, n_checks;

  // Device under test with short operation and hold counts.
  flp_lock_cmd #(.OP_CYC(4), .HOLD_CYC(2)) flp_lock_cmd_i (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
    .sck_in(sck), .cs_b_in(cs_b), .si_in(si), .so_out(so),
    .so_oe_out(so_oe), .pwd_mode_bit_in(pwd_mode), .bp_volatile_in(bp_vol),
    .bp_nv_value_in(3'h5), .bp_wr_in(bp_wr), .bp_wr_data_in(3'h2),
    .freeze_set_in(frz_set), .cont_read_enter_in(cr_in),
    .prog_fail_in(prog_fail), .busy_flag_out(busy), .wr_en_latch_out(write_enable_latch),
    .prog_err_out(perr), .lock_reg_out(lock), .freeze_out(frz),
    .block_protect_out(bp), .cont_read_out(cr), .reset_hold_out(hold));

  // Host side of the serial link.
  flp_host_model flp_host_model_i (
    .sck_out(sck), .cs_b_out(cs_b), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));

  // System clock at 250 MHz.
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic check(input string name, input logic [131:0] exp,
                       input logic [131:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // Waits a bounded time for busy (sel 0) or hold (sel 1) to reach v.
  task automatic wait_for(input int sel, input logic v);
    for (int k = 0; k < 40 && (sel ? hold : busy) !== v; k++)
      @(negedge sys_clk_in);
    if ((sel ? hold : busy) !== v) begin
      $display("[ERR] wait on flag %0d expected %b", sel, v);
      bad_count++;
      stop_test();
    end
  endtask

  // Sends one frame and lets the flags settle on the system side.
  task automatic send(input int n, input logic [143:0] tx);
    flp_host_model_i.frame(n, tx, rx, oe);
    repeat (12) @(negedge sys_clk_in);
  endtask

  // Hardware reset with the given protection mode level.
  task automatic hw_reset(input logic mode);
    pwd_mode = mode;
    rst_b_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
  endtask

  // Orders password bytes so that the low byte goes out first.
  function automatic logic [63:0] swap(input logic [63:0] p);
    logic [63:0] s;
    for (int k = 0; k < 8; k++) s[63-8*k -: 8] = p[8*k +: 8];
    return s;
  endfunction

  // Main sequence of command frames and expected results.
  initial begin
    {rst_b_in, bp_vol, bp_wr, frz_set, cr_in} = '0;
    pwd_mode = 1'b1;
    clk_en = 1'b1;
    prog_fail = 1'b0;
    bad_count = 0;
    n_checks = 0;
    ps = swap(64'h0123_4567_89ab_cdef);  // Low byte first.
    hw_reset(1'b1);
    check("lock_reg_out", 8'h01, lock);
    send(24, {8'ha7, 16'h0});  // Idle before reading.
    check("lock read", 17'h10101, {oe, rx[15:0]});
    send(8, 8'ha6);
    check("lock_reg_out", 8'h01, lock);
    send(8, 8'h06);
    check("wr_en_latch_out", 1'b1, write_enable_latch);
    send(9, {8'ha6, 1'b0});
    check("lock_reg_out", 8'h01, lock);
    flp_host_model_i.frame(8, 8'ha6, rx, oe);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check("lock_reg_out", 8'h00, lock);
    check("wr_en_latch_out", 1'b0, write_enable_latch);
    send(8, 8'h06);
    send(72, {8'he8, ps});
    check("program flags", 3'b000, {busy, write_enable_latch, perr});
    send(136, {8'he7, 128'h0});
    check("password read", {1'b1, ps, ps}, {oe, rx[127:0]});
    send(72, {8'he9, ~ps});
    check("unlock fail", 2'b11, {busy, perr});
    send(24, {8'ha7, 16'h0});
    check("so_oe_out", 1'b0, oe);
    send(8, 8'h30);
    check("status clear", 2'b00, {busy, perr});
    send(72, {8'he9, ps});
    check("lock_reg_out", 8'h01, lock);
    bp_vol = 1'b1;
    bp_wr = 1'b1;
    @(negedge sys_clk_in);
    {bp_wr, frz_set} = 2'b01;
    @(negedge sys_clk_in);
    frz_set = 1'b0;
    flp_host_model_i.frame(8, 8'hf0, rx, oe);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    check("soft reset", {8'h01, 1'b1, 3'h2}, {lock, frz, bp});
    hw_reset(1'b0);
    check("hard reset", {8'h00, 1'b0, 3'h5}, {lock, frz, bp});
    send(136, {8'he7, 128'h0});
    check("so_oe_out", 1'b0, oe);
    send(8, 8'h06);
    send(72, {8'he8, ~ps});
    check("program ignored", 2'b01, {busy, write_enable_latch});
    cr_in = 1'b1;
    @(negedge sys_clk_in);
    cr_in = 1'b0;
    @(negedge sys_clk_in);
    check("cont_read_out", 1'b1, cr);
    send(8, 8'hff);
    check("cont_read_out", 1'b0, cr);
    stop_test();
  end
endmodule

`default_nettype wire
